/* File: sleep_wake_consts.vh */
`ifndef SLEEP_WAKE_CONSTS_VH
`define SLEEP_WAKE_CONSTS_VH

// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_SLEEP_CONTROL 2'h0
`define IDX_REGULATOR_CONTROL 2'h1
`define IDX_GUARD 2'h2
`define IDX_STATUS 2'h3

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define SC_ARM_BIT 0
`define SC_MODE_LSB 1
`define SC_MODE_MSB 3
`define RC_DRIVE_LSB 0
`define RC_DRIVE_MSB 2
`define RC_HOT_BIT 4
`define SLEEP_CONTROL_RESET 8'h00
`define REGULATOR_CONTROL_RESET 8'h00
`define SLEEP_CONTROL_MASK 8'h0F
`define REGULATOR_CONTROL_MASK 8'h17

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define MODE_IDLE 3'h0
`define MODE_STANDBY 3'h1
`define MODE_POWER_DOWN 3'h2
`define DRIVE_AUTO 3'h0
`define DRIVE_FULL 3'h1

// ----------------------------------------------------------------
// unlock key and timing counts
// ----------------------------------------------------------------
`define IO_REGISTER_KEY 8'hA5
`define GUARD_INSTRUCTIONS 3'h4
`define WAKE_CYCLES 3'h6

`endif

/* File: wake_timer.v */
`timescale 1ns/10ps
// counts the fixed wake-up cycles once the clock sources are back
module wake_timer #(
  parameter WIDTH = 3
) (
  // clock and reset
  input wire clk_in,
  input wire rstn_in,
  // control
  input wire start_in,
  input wire [WIDTH-1:0] cycles_in,
  // status
  output wire busy_out,
  output reg done_out
);

  reg [WIDTH-1:0] remaining;

  // load on start, count down, pulse done on the last cycle
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      remaining <= {WIDTH{1'b0}};
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        remaining <= cycles_in;
      end else if (remaining != {WIDTH{1'b0}}) begin
        remaining <= remaining - {{(WIDTH-1){1'b0}}, 1'b1};
        done_out <= (remaining == {{(WIDTH-1){1'b0}}, 1'b1});
      end
    end
  end

  assign busy_out = (remaining != {WIDTH{1'b0}});

endmodule // wake_timer

/* File: sleep_wake_controller.v */
`timescale 1ns/10ps
`include "sleep_wake_consts.vh"

module sleep_wake_controller (
  // clock and reset
  input wire CORE_CLK_IN,
  input wire RSTN_IN,
  // avalon-mm register slave
  input wire [1:0] AVS_ADDRESS_IN,
  input wire AVS_READ_IN,
  input wire AVS_WRITE_IN,
  input wire [7:0] AVS_WRITEDATA_IN,
  output reg [7:0] AVS_READDATA_OUT,
  output wire AVS_WAITREQUEST_OUT,
  // cpu side
  input wire SLEEP_INSTR_IN,
  input wire INSTR_DONE_IN,
  input wire DEBUG_BREAK_IN,
  // pending wake interrupts
  input wire PIN_SYNC_IRQ_IN,
  input wire PIN_ASYNC_IRQ_IN,
  input wire LEVEL_MON_IRQ_IN,
  input wire RTC_TICK_IRQ_IN,
  input wire RTC_OTHER_IRQ_IN,
  input wire TWO_WIRE_MATCH_IRQ_IN,
  input wire LOGIC_IRQ_IN,
  input wire USART_SOF_IRQ_IN,
  input wire ANALOG_TIMER_IRQ_IN,
  input wire OTHER_IRQ_IN,
  // peripheral configuration and analog status
  input wire RTC_KEEP_IN,
  input wire MAIN_KEEP_IN,
  input wire LOGIC_KEEP_IN,
  input wire [1:0] LUT_FILTER_SELECT_IN,
  input wire [1:0] LUT_EDGE_DETECT_IN,
  input wire SLOW_OSC_SELECTED_IN,
  input wire SLOW_OSC_USED_IN,
  input wire BROWNOUT_WAIT_EN_IN,
  input wire BROWNOUT_READY_IN,
  input wire OSC_READY_IN,
  // clock gating and regulator controls
  output reg CPU_CLK_EN_OUT,
  output reg MAIN_CLK_EN_OUT,
  output reg PERIPH_CLK_EN_OUT,
  output reg RTC_CLK_EN_OUT,
  output reg LOGIC_CLK_EN_OUT,
  output reg SLOW_OSC_EN_OUT,
  output reg REG_FULL_DRIVE_OUT,
  output reg HOT_LEAK_CUT_OUT,
  output reg ASLEEP_OUT
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam ST_ACTIVE = 3'h0;
  localparam ST_SLEEP = 3'h1;
  localparam ST_WAKE_OSC = 3'h2;
  localparam ST_WAKE_CNT = 3'h3;
  localparam ST_WAKE_BROWNOUT = 3'h4;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [2:0] slept_mode;
  reg slept_hot;
  reg ack;
  reg [2:0] guard_left;
  reg [7:0] sleep_control;
  reg [7:0] regulator_control;
  reg timer_start;
  wire timer_busy;
  wire timer_done;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // reserved encodings above power-down enter no mode
  function mode_valid;
    input [2:0] m;
    begin
      mode_valid = (m == `MODE_IDLE) || (m == `MODE_STANDBY) ||
                   (m == `MODE_POWER_DOWN);
    end
  endfunction

  // main clock keeps running in idle, and in standby if kept
  function main_kept;
    input [2:0] m;
    input keep;
    begin
      main_kept = (m == `MODE_IDLE) ||
                  ((m == `MODE_STANDBY) && keep);
    end
  endfunction

  // ----------------------------------------------------------------
  // field views
  // ----------------------------------------------------------------
  wire arm = sleep_control[`SC_ARM_BIT];
  wire [2:0] mode = sleep_control[`SC_MODE_MSB:`SC_MODE_LSB];
  wire [2:0] drive = regulator_control[`RC_DRIVE_MSB:`RC_DRIVE_LSB];
  wire hot_leakage_cut = regulator_control[`RC_HOT_BIT];
  wire drive_auto = (drive == `DRIVE_AUTO);
  wire lut_async = (LUT_FILTER_SELECT_IN == 2'h0) &&
                   (LUT_EDGE_DETECT_IN == 2'h0);

  // ----------------------------------------------------------------
  // avalon-mm slave: one wait cycle on every access
  // ----------------------------------------------------------------
  wire req = AVS_READ_IN | AVS_WRITE_IN;
  wire wr_take = AVS_WRITE_IN & ack;
  assign AVS_WAITREQUEST_OUT = req & ~ack;

  // ack toggles so the master sees waitrequest low on the second edge
  always @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // read data is captured on the first edge and stands at the second
  always @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      AVS_READDATA_OUT <= 8'h00;
    end else if (AVS_READ_IN & ~ack) begin
      case (AVS_ADDRESS_IN)
        `IDX_SLEEP_CONTROL: AVS_READDATA_OUT <= sleep_control;
        `IDX_REGULATOR_CONTROL: AVS_READDATA_OUT <= regulator_control;
        `IDX_STATUS: AVS_READDATA_OUT <= {3'h0,
            (guard_left != 3'h0), ASLEEP_OUT, state};
        default: AVS_READDATA_OUT <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sleep control register
  // ----------------------------------------------------------------
  always @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      sleep_control <= `SLEEP_CONTROL_RESET;
    end else if (wr_take && AVS_ADDRESS_IN == `IDX_SLEEP_CONTROL) begin
      sleep_control <= AVS_WRITEDATA_IN & `SLEEP_CONTROL_MASK;
    end
  end

  // ----------------------------------------------------------------
  // change guard: key opens a window of cpu instructions
  // ----------------------------------------------------------------
  wire key_write = wr_take && (AVS_ADDRESS_IN == `IDX_GUARD) &&
                   (AVS_WRITEDATA_IN == `IO_REGISTER_KEY);
  wire reg_write = wr_take && (AVS_ADDRESS_IN == `IDX_REGULATOR_CONTROL);

  // a wrong key or the protected write itself closes the window
  always @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      guard_left <= 3'h0;
    end else if (key_write) begin
      guard_left <= `GUARD_INSTRUCTIONS;
    end else if (reg_write ||
                 (wr_take && AVS_ADDRESS_IN == `IDX_GUARD)) begin
      guard_left <= 3'h0;
    end else if (INSTR_DONE_IN && guard_left != 3'h0) begin
      guard_left <= guard_left - 3'h1;
    end
  end

  // protected register takes a write only while the window is open
  always @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      regulator_control <= `REGULATOR_CONTROL_RESET;
    end else if (reg_write && guard_left != 3'h0) begin
      regulator_control <= AVS_WRITEDATA_IN &
                           `REGULATOR_CONTROL_MASK;
    end
  end

  // ----------------------------------------------------------------
  // wake decision for the mode latched at sleep entry
  // ----------------------------------------------------------------
  reg wake_req;

  always @* begin
    wake_req = 1'b0;
    case (slept_mode)
      `MODE_IDLE: begin
        wake_req = PIN_SYNC_IRQ_IN | PIN_ASYNC_IRQ_IN | LEVEL_MON_IRQ_IN |
                   RTC_TICK_IRQ_IN | RTC_OTHER_IRQ_IN |
                   TWO_WIRE_MATCH_IRQ_IN | LOGIC_IRQ_IN |
                   ANALOG_TIMER_IRQ_IN | OTHER_IRQ_IN;
      end
      `MODE_STANDBY: begin
        // synchronous pin sensing needs the peripheral clock; the tick
        // needs no keep bit, only the other rtc functions do
        wake_req = PIN_ASYNC_IRQ_IN |
                   (PIN_SYNC_IRQ_IN & MAIN_KEEP_IN) |
                   LEVEL_MON_IRQ_IN | TWO_WIRE_MATCH_IRQ_IN | LOGIC_IRQ_IN |
                   RTC_TICK_IRQ_IN |
                   (RTC_OTHER_IRQ_IN & RTC_KEEP_IN) |
                   USART_SOF_IRQ_IN | ANALOG_TIMER_IRQ_IN;
      end
      `MODE_POWER_DOWN: begin
        wake_req = PIN_ASYNC_IRQ_IN | LEVEL_MON_IRQ_IN |
                   RTC_TICK_IRQ_IN |
                   (TWO_WIRE_MATCH_IRQ_IN & ~slept_hot) |
                   (LOGIC_IRQ_IN & lut_async & ~slept_hot);
      end
      default: wake_req = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // sleep state machine
  // ----------------------------------------------------------------
  wire osc_stopped = ~main_kept(slept_mode, MAIN_KEEP_IN);
  wire enter = SLEEP_INSTR_IN & arm & mode_valid(mode);

  always @* begin
    next_state = state;
    timer_start = 1'b0;
    case (state)
      ST_ACTIVE: begin
        if (enter) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (DEBUG_BREAK_IN) begin
          next_state = ST_ACTIVE;
        end else if (wake_req && osc_stopped) begin
          next_state = ST_WAKE_OSC;
        end else if (wake_req) begin
          next_state = ST_WAKE_CNT;
          timer_start = 1'b1;
        end
      end
      ST_WAKE_OSC: begin
        // oscillator ready already covers regulator start-up
        if (OSC_READY_IN) begin
          next_state = ST_WAKE_CNT;
          timer_start = 1'b1;
        end
      end
      ST_WAKE_CNT: begin
        if (timer_done && BROWNOUT_WAIT_EN_IN && !BROWNOUT_READY_IN) begin
          next_state = ST_WAKE_BROWNOUT;
        end else if (timer_done) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_WAKE_BROWNOUT: begin
        if (BROWNOUT_READY_IN) begin
          next_state = ST_ACTIVE;
        end
      end
      default: next_state = ST_ACTIVE;
    endcase
  end

  // state and the mode captured when the sleep instruction ran
  always @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state <= ST_ACTIVE;
      slept_mode <= `MODE_IDLE;
      slept_hot <= 1'b0;
    end else begin
      state <= next_state;
      if (state == ST_ACTIVE && enter) begin
        slept_mode <= mode;
        slept_hot <= hot_leakage_cut & drive_auto;
      end
    end
  end

  wake_timer #(
    .WIDTH(3)
  ) u_wake_timer (
    .clk_in(CORE_CLK_IN),
    .rstn_in(RSTN_IN),
    .start_in(timer_start),
    .cycles_in(`WAKE_CYCLES),
    .busy_out(timer_busy),
    .done_out(timer_done)
  );

  // ----------------------------------------------------------------
  // clock enables and regulator controls
  // ----------------------------------------------------------------
  reg next_cpu;
  reg next_main;
  reg next_periph;
  reg next_rtc;
  reg next_logic;
  reg next_slow;
  reg next_full;
  reg next_hot;

  // outside sleep every clock but the cpu's runs, the cpu's only when active; a stopped oscillator restarts first
  always @* begin
    next_cpu = (state == ST_ACTIVE);
    next_main = 1'b1;
    next_periph = 1'b1;
    next_rtc = 1'b1;
    next_logic = 1'b1;
    next_slow = 1'b1;
    next_hot = 1'b0;
    if (state == ST_SLEEP) begin
      case (slept_mode)
        `MODE_STANDBY: begin
          next_main = MAIN_KEEP_IN;
          next_periph = MAIN_KEEP_IN;
          next_rtc = RTC_KEEP_IN | SLOW_OSC_USED_IN;
          next_logic = LOGIC_KEEP_IN;
          next_slow = RTC_KEEP_IN | SLOW_OSC_USED_IN;
        end
        `MODE_POWER_DOWN: begin
          next_main = 1'b0;
          next_periph = 1'b0;
          next_logic = 1'b0;
          next_rtc = SLOW_OSC_USED_IN;
          next_slow = SLOW_OSC_USED_IN;
          next_hot = slept_hot;
        end
        default: begin
          next_main = 1'b1;
        end
      endcase
    end
    // auto drive saves power in deep sleep or on the slow oscillator
    if (drive_auto) begin
      next_full = ~SLOW_OSC_SELECTED_IN &
                  ~(state == ST_SLEEP &&
                    slept_mode != `MODE_IDLE);
    end else begin
      // full drive, and reserved codes fall back to the safe full drive
      next_full = 1'b1;
    end
  end

  // registered so the gating lines never glitch
  always @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      CPU_CLK_EN_OUT <= 1'b1;
      MAIN_CLK_EN_OUT <= 1'b1;
      PERIPH_CLK_EN_OUT <= 1'b1;
      RTC_CLK_EN_OUT <= 1'b1;
      LOGIC_CLK_EN_OUT <= 1'b1;
      SLOW_OSC_EN_OUT <= 1'b1;
      REG_FULL_DRIVE_OUT <= 1'b1;
      HOT_LEAK_CUT_OUT <= 1'b0;
      ASLEEP_OUT <= 1'b0;
    end else begin
      CPU_CLK_EN_OUT <= next_cpu;
      MAIN_CLK_EN_OUT <= next_main;
      PERIPH_CLK_EN_OUT <= next_periph;
      RTC_CLK_EN_OUT <= next_rtc;
      LOGIC_CLK_EN_OUT <= next_logic;
      SLOW_OSC_EN_OUT <= next_slow;
      REG_FULL_DRIVE_OUT <= next_full;
      HOT_LEAK_CUT_OUT <= next_hot;
      // stays asleep through the count state until the core clock returns
      ASLEEP_OUT <= (state == ST_SLEEP) | timer_busy |
                    (state == ST_WAKE_CNT) | (state == ST_WAKE_OSC) |
                    (state == ST_WAKE_BROWNOUT);
    end
  end

endmodule // sleep_wake_controller

/* File: sleep_wake_controller_assertions.sv */
`timescale 1ns/10ps
// ------------------------------------------------
// port checker for the sleep and wake controller
// ------------------------------------------------
module sleep_wake_controller_assertions (
  // clock and reset
  input wire CORE_CLK_IN,
  input wire RSTN_IN,
  // register bus
  input wire [1:0] AVS_ADDRESS_IN,
  input wire AVS_READ_IN,
  input wire AVS_WRITE_IN,
  input wire [7:0] AVS_WRITEDATA_IN,
  input wire AVS_WAITREQUEST_OUT,
  // cpu and status inputs
  input wire SLEEP_INSTR_IN,
  input wire DEBUG_BREAK_IN,
  input wire SLOW_OSC_SELECTED_IN,
  input wire BROWNOUT_WAIT_EN_IN,
  input wire BROWNOUT_READY_IN,
  input wire OSC_READY_IN,
  // controls
  input wire CPU_CLK_EN_OUT,
  input wire REG_FULL_DRIVE_OUT,
  input wire HOT_LEAK_CUT_OUT,
  input wire ASLEEP_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  reg [3:0] sc;
  // shadow of sleep control, so a strobe can be judged by its settings
  always @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN)
      sc <= 4'h0;
    else if (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == 2'h0)
      sc <= AVS_WRITEDATA_IN[3:0];
  end
  wire armed_ok = sc[0] && sc[3:1] <= 3'h2;
  wire held = ASLEEP_OUT && !CPU_CLK_EN_OUT && !DEBUG_BREAK_IN;
  sequence req_wait;
    (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT;
  endsequence
  sequence req_ack;
    !AVS_WAITREQUEST_OUT;
  endsequence
  sequence awake_strobe;
    SLEEP_INSTR_IN && !ASLEEP_OUT && CPU_CLK_EN_OUT;
  endsequence
  chk_bus_one_wait: assert property (req_wait |=> req_ack)
    else $error("bus access waited more than one cycle");
  chk_sleep_entry: assert property (
    awake_strobe ##0 armed_ok |-> ##[1:2] !CPU_CLK_EN_OUT)
    else $error("armed sleep strobe did not stop the core clock");
  chk_strobe_refused: assert property (
    awake_strobe ##0 (!armed_ok && !$past(SLEEP_INSTR_IN))
    |=> CPU_CLK_EN_OUT [*2])
    else $error("refused sleep strobe stopped the core clock");
  // a debug break wakes at once, so the cycle after it is not held
  chk_osc_wait: assert property (
    held && !$past(DEBUG_BREAK_IN) && !OSC_READY_IN |=> !CPU_CLK_EN_OUT)
    else $error("core woke before oscillator ready");
  chk_brownout_wait: assert property (
    held && BROWNOUT_WAIT_EN_IN && !BROWNOUT_READY_IN |=> !CPU_CLK_EN_OUT)
    else $error("core woke before brown-out ready");
  chk_debug_wake: assert property (
    ASLEEP_OUT && DEBUG_BREAK_IN && !CPU_CLK_EN_OUT
    |-> ##[1:3] CPU_CLK_EN_OUT)
    else $error("debug break did not wake the core");
  chk_leak_scope: assert property (
    HOT_LEAK_CUT_OUT |-> ASLEEP_OUT && !CPU_CLK_EN_OUT)
    else $error("leak cut active while awake");
  chk_full_active: assert property (
    !ASLEEP_OUT && !$past(ASLEEP_OUT) && !SLOW_OSC_SELECTED_IN
    && !$past(SLOW_OSC_SELECTED_IN) |-> REG_FULL_DRIVE_OUT)
    else $error("regulator not at full drive while active");
endmodule // sleep_wake_controller_assertions

bind sleep_wake_controller sleep_wake_controller_assertions
  sleep_wake_controller_assertions_inst (.CORE_CLK_IN, .RSTN_IN,
  .AVS_ADDRESS_IN, .AVS_READ_IN, .AVS_WRITE_IN, .AVS_WRITEDATA_IN,
  .AVS_WAITREQUEST_OUT, .SLEEP_INSTR_IN, .DEBUG_BREAK_IN,
  .SLOW_OSC_SELECTED_IN, .BROWNOUT_WAIT_EN_IN, .BROWNOUT_READY_IN,
  .OSC_READY_IN,
  .CPU_CLK_EN_OUT, .REG_FULL_DRIVE_OUT, .HOT_LEAK_CUT_OUT, .ASLEEP_OUT);

/* File: cpu_core_model.sv */
`timescale 1ns/10ps
// ------------------------------------------------
// cpu core: sleep strobe and retired instructions
// ------------------------------------------------
module cpu_core_model (
  // clock and reset
  input wire clk_in,
  input wire rstn_in,
  // requests from the bench
  input wire sleep_req_in,
  input wire step_in,
  // core clock gate
  input wire cpu_clk_en_in,
  // strobes to the controller
  output reg sleep_instr_out,
  output reg instr_done_out
);
  // a gated core retires nothing, so no strobe can leak out of sleep
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sleep_instr_out <= 1'h0;
      instr_done_out <= 1'h0;
    end else begin
      sleep_instr_out <= sleep_req_in & cpu_clk_en_in;
      instr_done_out <= step_in & cpu_clk_en_in;
    end
  end
endmodule // cpu_core_model

/* File: tb_sleep_wake_controller.sv */
`timescale 1ns/10ps
`include "sleep_wake_consts.vh"
module tb_sleep_wake_controller;
  // ------------------------------------------------
  // stimulus and design
  // ------------------------------------------------
  reg clk = 1'h0, rstn = 1'h0, rd = 1'h0, wr = 1'h0, dbg = 1'h0;
  reg sreq = 1'h0, step = 1'h0, rtc_sb = 1'h0, main_sb = 1'h0;
  reg logic_sb = 1'h0, slow_sel = 1'h0, slow_used = 1'h0, bo_en = 1'h0;
  reg bo_rdy = 1'h1, osc = 1'h0;
  reg [1:0] adr = 2'h0, filt = 2'h0, edg = 2'h0;
  reg [7:0] wd = 8'h00, q, r;
  reg [9:0] irq = 10'h000;
  wire [7:0] rdata;
  wire wq, sinstr, idone, cen, men, pen, ren, lcen, soen, full, leak, slp;
  int n_mismatch = 0, checks_done = 0, n, oc = 0;
  sleep_wake_controller sleep_wake_controller_inst (
    .CORE_CLK_IN(clk), .RSTN_IN(rstn), .AVS_ADDRESS_IN(adr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wq),
    .SLEEP_INSTR_IN(sinstr), .INSTR_DONE_IN(idone),
    .DEBUG_BREAK_IN(dbg), .PIN_SYNC_IRQ_IN(irq[0]),
    .PIN_ASYNC_IRQ_IN(irq[1]), .LEVEL_MON_IRQ_IN(irq[2]),
    .RTC_TICK_IRQ_IN(irq[3]), .RTC_OTHER_IRQ_IN(irq[4]),
    .TWO_WIRE_MATCH_IRQ_IN(irq[5]), .LOGIC_IRQ_IN(irq[6]),
    .USART_SOF_IRQ_IN(irq[7]), .ANALOG_TIMER_IRQ_IN(irq[8]),
    .OTHER_IRQ_IN(irq[9]), .RTC_KEEP_IN(rtc_sb),
    .MAIN_KEEP_IN(main_sb), .LOGIC_KEEP_IN(logic_sb),
    .LUT_FILTER_SELECT_IN(filt), .LUT_EDGE_DETECT_IN(edg),
    .SLOW_OSC_SELECTED_IN(slow_sel), .SLOW_OSC_USED_IN(slow_used),
    .BROWNOUT_WAIT_EN_IN(bo_en), .BROWNOUT_READY_IN(bo_rdy),
    .OSC_READY_IN(osc),
    .CPU_CLK_EN_OUT(cen), .MAIN_CLK_EN_OUT(men), .PERIPH_CLK_EN_OUT(pen),
    .RTC_CLK_EN_OUT(ren), .LOGIC_CLK_EN_OUT(lcen), .SLOW_OSC_EN_OUT(soen),
    .REG_FULL_DRIVE_OUT(full), .HOT_LEAK_CUT_OUT(leak), .ASLEEP_OUT(slp));
  cpu_core_model cpu_core_model_inst (.clk_in(clk), .rstn_in(rstn),
    .sleep_req_in(sreq), .step_in(step), .cpu_clk_en_in(cen),
    .sleep_instr_out(sinstr), .instr_done_out(idone));
  initial begin
    forever #20 clk = ~clk;
  end
  // main oscillator: dead while gated, ready six cycles after its enable
  always @(posedge clk) begin
    if (men !== 1'h1) begin
      oc <= 0;
      osc <= 1'h0;
    end else if (oc < 5)
      oc <= oc + 1;
    else
      osc <= 1'h1;
  end
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task chk(input string s, input [7:0] e, input [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task bus(input w, input [1:0] a, input [7:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    // only the bench watchdog ends a wait that never sees an answer
    do @(posedge clk); while (wq !== 1'h0);
    q = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  task strobe;
    @(posedge clk);
    sreq <= 1'h1;
    @(posedge clk);
    sreq <= 1'h0;
    repeat (5) @(posedge clk);
  endtask
  task go(input [2:0] m);
    bus(1'h1, 2'h0, {4'h0, m, 1'h1});
    strobe;
  endtask
  // raise one wake line; n counts half-way samples until the core runs
  task kick(input int i);
    @(posedge clk);
    irq[i] <= 1'h1;
    n = 0;
    while (cen !== 1'h1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    irq <= 10'h000;
  endtask
  task unlock(input [7:0] d);
    bus(1'h1, 2'h2, `IO_REGISTER_KEY);
    bus(1'h1, 2'h1, d);
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // hang guard, far beyond the sequence below
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    wrap_up;
  end
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  initial begin
    void'($urandom(32'h7138));
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    bus(1'h0, 2'h0, 8'h00);
    chk("sleep_control", `SLEEP_CONTROL_RESET, q);
    bus(1'h0, 2'h1, 8'h00);
    chk("regulator_control", `REGULATOR_CONTROL_RESET, q);
    r = 8'($urandom);
    bus(1'h1, 2'h0, r);
    bus(1'h0, 2'h0, 8'h00);
    chk("sleep_control", r & `SLEEP_CONTROL_MASK, q);
    bus(1'h1, 2'h1, r);
    bus(1'h0, 2'h1, 8'h00);
    chk("unguarded write", 8'h00, q);
    unlock(r);
    bus(1'h0, 2'h1, 8'h00);
    chk("guarded write", r & `REGULATOR_CONTROL_MASK, q);
    // three retired instructions leave the guard window open, four close it
    for (int k = 3; k <= 4; k++) begin
      bus(1'h1, 2'h2, `IO_REGISTER_KEY);
      step <= 1'h1;
      repeat (k) @(posedge clk);
      step <= 1'h0;
      repeat (2) @(posedge clk);
      bus(1'h1, 2'h1, {3'h0, k[0], 4'h0});
      bus(1'h0, 2'h1, 8'h00);
      chk("guard window", 8'h10, q);
    end
    bus(1'h1, 2'h0, 8'h00);
    strobe;
    chk("cpu clock", 8'h01, cen);
    for (int m = 3; m < 8; m++) begin
      go(m[2:0]);
      chk("reserved mode", 8'h01, cen);
    end
    go(`MODE_POWER_DOWN);
    chk("leak cut", 8'h01, leak);
    chk("full drive", 8'h00, full);
    kick(5);
    chk("two-wire wake", 8'h00, cen);
    dbg <= 1'h1;
    @(posedge clk);
    dbg <= 1'h0;
    repeat (4) @(posedge clk);
    chk("debug wake", 8'h01, cen);
    unlock(8'h00);
    {rtc_sb, main_sb, logic_sb} <= 3'($urandom);
    go(`MODE_STANDBY);
    chk("main clock", main_sb, men);
    chk("rtc clock", rtc_sb, ren);
    chk("logic clock", logic_sb, lcen);
    kick(7);
    chk("frame wake", 8'h01, cen);
    slow_used <= 1'($urandom);
    filt <= 2'h1;
    go(`MODE_POWER_DOWN);
    chk("main clock", 8'h00, men);
    chk("periph clock", 8'h00, pen);
    chk("slow osc", slow_used, soen);
    kick(0);
    chk("sync pin wake", 8'h00, cen);
    kick(6);
    chk("filtered lut wake", 8'h00, cen);
    {filt, edg} <= 4'h2;
    kick(6);
    chk("edge lut wake", 8'h00, cen);
    edg <= 2'h0;
    kick(6);
    chk("async lut wake", 8'h01, cen);
    go(`MODE_POWER_DOWN);
    kick(1);
    chk("async pin wake", 8'h01, cen);
    unlock(8'h11);
    go(`MODE_POWER_DOWN);
    chk("leak in full drive", 8'h00, leak);
    chk("full drive in sleep", 8'h01, full);
    kick(1);
    slow_sel <= 1'h1;
    unlock(8'h00);
    repeat (2) @(posedge clk);
    chk("slow osc drive", 8'h00, full);
    slow_sel <= 1'h0;
    bo_en <= 1'h1;
    go(`MODE_IDLE);
    chk("main clock", 8'h01, men);
    kick(7);
    chk("frame in idle", 8'h00, cen);
    kick(9);
    chk("idle wake time", `WAKE_CYCLES + 4, n);
    bo_rdy <= 1'h0;
    go(`MODE_IDLE);
    kick(2);
    chk("wake before ready", 8'h00, cen);
    bo_rdy <= 1'h1;
    repeat (4) @(posedge clk);
    chk("wake after ready", 8'h01, cen);
    wrap_up;
  end
endmodule // tb_sleep_wake_controller
